// ---- core/power_seq_pkg.sv ----
// power_seq_pkg: shared constants for the five-channel power sequencer
// assumes clk is the master oscillator domain at 200 MHz
package power_seq_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int ONESHOT_NS        = 300;
    localparam int ONESHOT_CYC       = (ONESHOT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OSC_PERIOD_CYC    = 400;
    localparam int SOFTSTART_OSC     = 4096;
    localparam int BUCK_DELAY_OSC    = 1024;
    localparam int FAULT_OSC         = 100000;
    // ************************************************************
    // duty ceiling in percent of the oscillator period
    // ************************************************************
    localparam int DUTY_MAX_PCT      = 85;
    localparam int DUTY_MIN_PCT      = 80;
    localparam int REF_W             = 12;
    localparam int NUM_AUX           = 3;
    localparam int NUM_CH            = 5;
    localparam int CH_BOOST          = 0;
    localparam int CH_BUCK           = 1;
    localparam int CH_AUX0           = 2;
    typedef enum logic [1:0] {
        SEQ_OFF     = 2'b00,
        SEQ_BOOST   = 2'b01,
        SEQ_RUN     = 2'b10,
        SEQ_LATCHED = 2'b11
    } seq_state_t;
endpackage

// ---- core/softstart_ramp.sv ----
// softstart_ramp: reference ramp from zero to full scale over a count of oscillator cycles
// assumes osc_tick is a one-cycle pulse per oscillator cycle on clk
module softstart_ramp
    import power_seq_pkg::*;
#(
    parameter int STEPS = SOFTSTART_OSC
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              run,
    input  wire logic              osc_tick,
    output logic [REF_W-1:0]       ref_level,
    output logic                   ramping
);
    if (STEPS < 2 || STEPS > (1 << REF_W)) begin : g_bad_steps
        $error("softstart_ramp: STEPS out of range");
    end
    logic [REF_W:0] cnt_r;
    logic [REF_W:0] cnt_nxt;
    // ************************************************************
    // ramp counter, restarts whenever the channel is dropped
    // ************************************************************
    always_comb begin
        cnt_nxt = cnt_r;
        if (!run)
            cnt_nxt = '0;
        else if (osc_tick && cnt_r < (REF_W+1)'(STEPS))
            cnt_nxt = cnt_r + 1'b1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end
    assign ramping   = run && cnt_r < (REF_W+1)'(STEPS);
    assign ref_level = (cnt_r >= (REF_W+1)'(STEPS)) ? {REF_W{1'b1}} : cnt_r[REF_W-1:0];
endmodule

// ---- core/multichannel_power_sequencer.sv ----
// multichannel_power_sequencer: sequencing, fault latch and aux gate timing
// assumes all status inputs are asynchronous pins; clk is the device clock
// What this block does
// - aux gate goes high at cycle start
// - gate drops at ramp over comp or ceiling
// - duty ceiling at least eighty, typically 85%
// - buck and aux held until boost regulates
// - continuous fault count latches all off
// - latch clears only by boost re-enable
// - fault ignored during channel soft-start
// - buck and aux reference ramp 4096 cycles
// - boost starts with no ramp
// - high enable input turns channel on
// - oscillator charges, 300ns discharge, repeats
// - startup oscillator until boost reaches 2.5V
// - reference on with buck enable and rail
// - slaves share the master timing signal
// - aux gates low in shutdown or thermal
// - buck soft-start 1024 cycles after regulation
module multichannel_power_sequencer
    import power_seq_pkg::*;
#(
    parameter int OSC_CYC   = OSC_PERIOD_CYC,
    parameter int FAULT_CNT = FAULT_OSC,
    parameter int BUCK_DLY  = BUCK_DELAY_OSC,
    parameter int SS_STEPS  = SOFTSTART_OSC
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                boost_enable_in,
    input  wire logic                buck_enable_in,
    input  wire logic                aux_one_enable_in,
    input  wire logic                aux_two_enable_in,
    input  wire logic                aux_three_enable_in,
    input  wire logic                boost_in_reg,
    input  wire logic                boost_above_startup,
    input  wire logic                buck_rail_above,
    input  wire logic [NUM_CH-1:0]   ch_in_reg,
    input  wire logic                thermal_limit,
    input  wire logic [REF_W-1:0]    aux_comp_level [NUM_AUX],
    output logic [NUM_AUX-1:0]       aux_gate_drive,
    output logic                     master_timing_node,
    output logic                     boost_switch_node,
    output logic                     boost_startup_osc,
    output logic                     buck_run,
    output logic [REF_W-1:0]         buck_ref,
    output logic [REF_W-1:0]         aux_ref [NUM_AUX],
    output logic                     ref_enable,
    output logic                     fault_latched
);
    localparam int DUTY_CYC = (OSC_CYC * DUTY_MAX_PCT) / 100;
    // ************************************************************
    // elaboration checks: counters below are sized for these ranges
    // ************************************************************
    if (OSC_CYC <= ONESHOT_CYC + 1 || OSC_CYC > (1 << 16)) begin : g_bad_osc
        $error("osc period too short for the one-shot or too long for its counter");
    end
    if (DUTY_CYC * 100 < OSC_CYC * DUTY_MIN_PCT) begin : g_bad_duty
        $error("duty ceiling below the guaranteed minimum");
    end
    if (FAULT_CNT < 2 || FAULT_CNT >= (1 << 17)) begin : g_bad_fault
        $error("fault count out of range");
    end
    if (BUCK_DLY < 1 || BUCK_DLY >= (1 << 11)) begin : g_bad_dly
        $error("buck delay out of range");
    end
    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    assign raw = {thermal_limit, buck_rail_above, boost_above_startup, boost_in_reg,
                  aux_three_enable_in, aux_two_enable_in, aux_one_enable_in,
                  buck_enable_in, boost_enable_in};
    logic [NUM_CH-1:0] reg_s1_r;
    logic [NUM_CH-1:0] reg_s2_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r     <= '0;
            s2_r     <= '0;
            reg_s1_r <= '0;
            reg_s2_r <= '0;
        end else begin
            s1_r     <= raw;
            s2_r     <= s1_r;
            reg_s1_r <= ch_in_reg;
            reg_s2_r <= reg_s1_r;
        end
    end
    logic boost_en, buck_en, thermal, boost_reg, boost_up, buck_rail;
    logic [NUM_AUX-1:0] aux_en;
    assign boost_en  = s2_r[0];
    assign buck_en   = s2_r[1];
    assign aux_en    = s2_r[4:2];
    assign boost_reg = s2_r[5];
    assign boost_up  = s2_r[6];
    assign buck_rail = s2_r[7];
    assign thermal   = s2_r[8];
    // ************************************************************
    // master oscillator: charge phase then one-shot discharge
    // ************************************************************
    logic [15:0] osc_r, osc_nxt;
    logic        tick;
    always_comb begin
        osc_nxt = (osc_r == 16'(OSC_CYC - 1)) ? 16'h0000 : osc_r + 16'h0001;
    end
    assign tick = (osc_r == 16'h0000);
    // ************************************************************
    // sequencer state
    // ************************************************************
    seq_state_t st_r, st_nxt;
    logic       boost_en_d_r;
    logic [10:0] dly_r, dly_nxt;
    logic       aux_go;
    logic       buck_go;
    logic [NUM_CH-1:0] ramp_busy;
    logic [NUM_CH-1:0] fault_hit;
    always_comb begin
        st_nxt  = st_r;
        dly_nxt = dly_r;
        unique case (st_r)
            SEQ_OFF:     if (boost_en) st_nxt = SEQ_BOOST;
            SEQ_BOOST:   if (!boost_en) st_nxt = SEQ_OFF;
                         else if (boost_reg) st_nxt = SEQ_RUN;
            SEQ_RUN:     if (!boost_en) st_nxt = SEQ_OFF;
                         else if (|fault_hit) st_nxt = SEQ_LATCHED;
            SEQ_LATCHED: if (boost_en && !boost_en_d_r) st_nxt = SEQ_BOOST;
        endcase
        if (st_nxt != SEQ_RUN)
            dly_nxt = '0;
        else if (tick && dly_r < 11'(BUCK_DLY))
            dly_nxt = dly_r + 11'h001;
    end
    assign aux_go  = (st_r == SEQ_RUN);
    assign buck_go = aux_go && buck_en && dly_r >= 11'(BUCK_DLY);
    // ************************************************************
    // soft-start ramps and per-channel fault counters
    // ************************************************************
    logic [NUM_AUX-1:0] aux_on;
    logic [REF_W-1:0]   aux_ref_w [NUM_AUX];
    logic [REF_W-1:0]   buck_ref_w;
    logic [16:0] fcnt_r [NUM_CH];
    logic [16:0] fcnt_nxt [NUM_CH];
    logic [NUM_CH-1:0] ch_active;
    assign ch_active = {aux_on, buck_go, st_r == SEQ_RUN};
    softstart_ramp #(.STEPS(SS_STEPS)) u_buck_ss (
        .clk(clk), .arst_n(arst_n), .run(buck_go), .osc_tick(tick),
        .ref_level(buck_ref_w), .ramping(ramp_busy[CH_BUCK]));
    assign ramp_busy[CH_BOOST] = 1'b0;
    genvar g;
    generate
        for (g = 0; g < NUM_AUX; g++) begin : g_aux
            assign aux_on[g] = aux_go && aux_en[g] && !thermal;
            softstart_ramp #(.STEPS(SS_STEPS)) u_ss (
                .clk(clk), .arst_n(arst_n), .run(aux_on[g]), .osc_tick(tick),
                .ref_level(aux_ref_w[g]), .ramping(ramp_busy[CH_AUX0+g]));
        end
        for (g = 0; g < NUM_CH; g++) begin : g_flt
            always_comb begin
                fcnt_nxt[g] = fcnt_r[g];
                if (!ch_active[g] || ramp_busy[g] || reg_s2_r[g])
                    fcnt_nxt[g] = '0;
                else if (tick && fcnt_r[g] < 17'(FAULT_CNT))
                    fcnt_nxt[g] = fcnt_r[g] + 17'h00001;
            end
            assign fault_hit[g] = fcnt_r[g] >= 17'(FAULT_CNT);
        end
    endgenerate
    // ************************************************************
    // aux gate timing
    // ************************************************************
    logic [NUM_AUX-1:0] gate_nxt;
    logic [REF_W-1:0]   saw;
    assign saw = REF_W'((32'(osc_r) << REF_W) / OSC_CYC);
    always_comb begin
        for (int i = 0; i < NUM_AUX; i++) begin
            gate_nxt[i] = aux_gate_drive[i];
            if (!aux_on[i] || st_nxt != SEQ_RUN)
                gate_nxt[i] = 1'b0;
            else if (osc_nxt == 16'h0000)
                gate_nxt[i] = 1'b1;
            else if (osc_nxt >= 16'(DUTY_CYC) || saw > aux_comp_level[i])
                gate_nxt[i] = 1'b0;
        end
    end
    // ************************************************************
    // registers and registered outputs
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_r              <= 16'(OSC_CYC - 1); // first edge opens a full one-shot
            st_r               <= SEQ_OFF;
            dly_r              <= '0;
            boost_en_d_r       <= 1'b0;
            aux_gate_drive     <= '0;
            master_timing_node <= 1'b0;
            boost_switch_node  <= 1'b0;
            boost_startup_osc  <= 1'b0;
            buck_run           <= 1'b0;
            buck_ref           <= '0;
            ref_enable         <= 1'b0;
            fault_latched      <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) fcnt_r[i] <= '0;
            for (int i = 0; i < NUM_AUX; i++) aux_ref[i] <= '0;
        end else begin
            osc_r              <= osc_nxt;
            st_r               <= st_nxt;
            dly_r              <= dly_nxt;
            boost_en_d_r       <= boost_en;
            aux_gate_drive     <= gate_nxt;
            master_timing_node <= osc_nxt < 16'(ONESHOT_CYC);
            boost_startup_osc  <= boost_en && !boost_up;
            boost_switch_node  <= boost_en && !boost_up && osc_nxt < 16'(OSC_CYC / 2);
            buck_run           <= buck_go;
            buck_ref           <= buck_ref_w;
            ref_enable         <= buck_en && buck_rail;
            fault_latched      <= (st_nxt == SEQ_LATCHED);
            for (int i = 0; i < NUM_CH; i++) fcnt_r[i] <= fcnt_nxt[i];
            for (int i = 0; i < NUM_AUX; i++) aux_ref[i] <= aux_ref_w[i];
        end
    end
endmodule

// ---- test/power_seq_partner.sv ----
// power_seq_partner: external switches and rails seen from the sequencer
// assumes rails settle at once; fail_mask forces a rail out of regulation
module power_seq_partner
    import power_seq_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic [NUM_AUX-1:0] aux_gate_drive,
    input  wire logic               buck_run,
    input  wire logic [NUM_CH-1:0]  fail_mask,
    output logic      [NUM_CH-1:0]  ch_in_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    // an aux rail stays regulated for two periods after its last gate pulse
    int                 idle_r [NUM_AUX];
    logic [NUM_AUX-1:0] aux_ok;
    always_ff @(posedge clk or negedge arst_n) begin
        for (int i = 0; i < NUM_AUX; i++) begin
            if (!arst_n) idle_r[i] <= 2 * OSC_PERIOD_CYC;
            else idle_r[i] <= aux_gate_drive[i] ? 0 : idle_r[i] + int'(idle_r[i] < 2 * OSC_PERIOD_CYC);
        end
    end
    always_comb foreach (aux_ok[i]) aux_ok[i] = idle_r[i] < 2 * OSC_PERIOD_CYC;
    assign ch_in_reg = ~fail_mask & {aux_ok, buck_run, 1'b1};
endmodule

// ---- test/power_seq_checker.sv ----
// power_seq_checker: port-level timing and shutdown properties
// assumes it is bound onto multichannel_power_sequencer
module power_seq_checker
    import power_seq_pkg::*;
#(
    parameter int OSC_CYC = OSC_PERIOD_CYC
) (
    input wire logic               clk,
    input wire logic               arst_n,
    input wire logic               boost_enable_in,
    input wire logic               buck_enable_in,
    input wire logic               boost_above_startup,
    input wire logic               buck_rail_above,
    input wire logic               thermal_limit,
    input wire logic [NUM_AUX-1:0] aux_gate_drive,
    input wire logic               master_timing_node,
    input wire logic               boost_startup_osc,
    input wire logic               buck_run,
    input wire logic               ref_enable,
    input wire logic               fault_latched
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ************
    // high-time counters
    // ************
    int node_r, node_nxt, gate_r, gate_nxt;
    always_comb begin
        node_nxt = master_timing_node ? node_r + 1 : 0;
        gate_nxt = aux_gate_drive[0] ? gate_r + 1 : 0;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            node_r <= 0;
            gate_r <= 0;
        end else begin
            node_r <= node_nxt;
            gate_r <= gate_nxt;
        end
    end
    property p_start; $rose(aux_gate_drive[0]) |-> master_timing_node; endproperty
    a_start: assert property (p_start) else $error("gate rose mid cycle");
    property p_ceil; gate_r <= OSC_CYC * DUTY_MAX_PCT / 100; endproperty
    a_ceil: assert property (p_ceil) else $error("gate over ceiling");
    property p_hold; (!boost_enable_in) [*6] |-> aux_gate_drive == '0 && !buck_run; endproperty
    a_hold: assert property (p_hold) else $error("channel on without boost");
    property p_latch; fault_latched [*2] |-> aux_gate_drive == '0 && !buck_run; endproperty
    a_latch: assert property (p_latch) else $error("channel on while latched");
    property p_keep; (fault_latched && !boost_enable_in) [*4] |=> fault_latched; endproperty
    a_keep: assert property (p_keep) else $error("latch cleared alone");
    property p_shot; $fell(master_timing_node) |-> node_r == ONESHOT_CYC; endproperty
    a_shot: assert property (p_shot) else $error("one-shot width");
    property p_boot; boost_above_startup [*4] |-> !boost_startup_osc; endproperty
    a_boot: assert property (p_boot) else $error("startup osc stuck");
    property p_ref; (buck_enable_in && buck_rail_above) [*4] |-> ref_enable; endproperty
    a_ref: assert property (p_ref) else $error("reference off");
    property p_heat; thermal_limit [*4] |-> aux_gate_drive == '0; endproperty
    a_heat: assert property (p_heat) else $error("gate on in thermal");
    c_latch: cover property ($rose(fault_latched));
    c_clear: cover property ($fell(fault_latched));
    c_buck: cover property ($rose(buck_run));
endmodule
bind multichannel_power_sequencer power_seq_checker #(.OSC_CYC(OSC_CYC)) chk (
    .clk, .arst_n, .boost_enable_in, .buck_enable_in, .boost_above_startup, .buck_rail_above, .thermal_limit,
    .aux_gate_drive, .master_timing_node, .boost_startup_osc, .buck_run, .ref_enable, .fault_latched);

// ---- test/multichannel_power_sequencer_test.sv ----
// multichannel_power_sequencer_test: directed and random checks of the sequencer
// assumes the partner model drives the regulation flags and the checker is bound
module multichannel_power_sequencer_test
    import power_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OC = OSC_PERIOD_CYC;
    logic clk, arst_n, boost_enable_in, buck_enable_in, aux_one_enable_in, aux_two_enable_in, aux_three_enable_in;
    logic boost_in_reg, boost_above_startup, buck_rail_above, thermal_limit, master_timing_node, boost_switch_node;
    logic boost_startup_osc, buck_run, ref_enable, fault_latched;
    logic [NUM_CH-1:0]  ch_in_reg, fail_mask;
    logic [NUM_AUX-1:0] aux_gate_drive;
    logic [REF_W-1:0]   buck_ref, aux_comp_level [NUM_AUX], aux_ref [NUM_AUX];
    int                 bad_count, checks_done, hi [NUM_AUX], rises, sw_hi;
    multichannel_power_sequencer #(.FAULT_CNT(20), .BUCK_DLY(4), .SS_STEPS(8)) uut (
        .clk, .arst_n, .boost_enable_in, .buck_enable_in, .aux_one_enable_in, .aux_two_enable_in,
        .aux_three_enable_in, .boost_in_reg, .boost_above_startup, .buck_rail_above, .ch_in_reg, .thermal_limit,
        .aux_comp_level, .aux_gate_drive, .master_timing_node, .boost_switch_node, .boost_startup_osc, .buck_run,
        .buck_ref, .aux_ref, .ref_enable, .fault_latched);
    power_seq_partner far (.clk, .arst_n, .aux_gate_drive, .buck_run, .fail_mask, .ch_in_reg);
    always #2.5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // counts gate high cycles and oscillator starts over n cycles
    task automatic measure(input int n);
        logic prev;
        prev = master_timing_node;
        hi = '{default: 0};
        rises = 0;
        sw_hi = 0;
        repeat (n) begin
            @(negedge clk);
            foreach (hi[i]) hi[i] += int'(aux_gate_drive[i]);
            sw_hi += int'(boost_switch_node);
            rises += int'(master_timing_node && !prev);
            prev = master_timing_node;
        end
    endtask
    // model: on-time ends at the sawtooth crossing or the duty ceiling
    function automatic int exp_w(input int comp);
        return (comp * OC / 4096 < OC * DUTY_MAX_PCT / 100) ? comp * OC / 4096 : OC * DUTY_MAX_PCT / 100;
    endfunction
    initial begin
        cyc(80000);
        bad_count++;
        final_report();
    end
    initial begin
        clk = 1'b0;
        {arst_n, boost_enable_in, thermal_limit, boost_in_reg, boost_above_startup, aux_three_enable_in, fail_mask} = '0;
        {buck_enable_in, buck_rail_above, aux_one_enable_in, aux_two_enable_in} = '1;
        void'($urandom(86128));
        aux_comp_level = '{12'hFFF, 12'h800, 12'(1024 + $urandom % 3072)};
        cyc(8);
        arst_n = 1'b1;
        boost_enable_in = 1'b1;
        measure(2000);
        check("gates early", hi[0] + hi[1], 0);
        check("buck early", buck_run, 0);
        check("startup osc", boost_startup_osc, 1);
        measure(2 * OC);
        check("startup switch", sw_hi, OC);
        boost_above_startup = 1'b1;
        cyc(10);
        check("startup osc off", boost_startup_osc, 0);
        check("startup switch off", boost_switch_node, 0);
        check("ref enable", ref_enable, 1);
        $display("test startup done");
        boost_in_reg = 1'b1;
        cyc(3 * OC);
        check("buck delay", buck_run, 0);
        check("buck ref zero", buck_ref, 0);
        check("aux ramping", aux_ref[0] < 12'hFFF, 1);
        cyc(14 * OC);
        check("buck run", buck_run, 1);
        check("buck ref", buck_ref, 12'hFFF);
        check("aux ref", aux_ref[1], 12'hFFF);
        measure(10 * OC);
        check("osc starts", rises, 10);
        check("disabled gate", hi[2], 0);
        for (int i = 0; i < 2; i++) check("width", hi[i] / 10 - exp_w(aux_comp_level[i]) inside {[-3:3]}, 1);
        aux_three_enable_in = 1'b1;
        cyc(10 * OC);
        measure(10 * OC);
        check("random width", hi[2] / 10 - exp_w(aux_comp_level[2]) inside {[-3:3]}, 1);
        check("aux three ref", aux_ref[2], 12'hFFF);
        thermal_limit = 1'b1;
        cyc(4);
        measure(OC);
        check("thermal gates", hi[0] + hi[1] + hi[2], 0);
        thermal_limit = 1'b0;
        buck_enable_in = 1'b0;
        cyc(10);
        check("ref off", ref_enable, 0);
        check("buck off", buck_run, 0);
        buck_enable_in = 1'b1;
        $display("test run done");
        repeat (2) begin
            fail_mask = 5'h04;
            cyc(15 * OC);
            fail_mask = 5'h00;
            cyc(2 * OC);
        end
        check("broken fault", fault_latched, 0);
        fail_mask = 5'h04;
        cyc(19 * OC);
        check("latch early", fault_latched, 0);
        cyc(4 * OC);
        check("latch", fault_latched, 1);
        fail_mask = 5'h00;
        cyc(2 * OC);
        check("latch holds", fault_latched, 1);
        boost_enable_in = 1'b0;
        cyc(10);
        boost_enable_in = 1'b1;
        fail_mask = 5'h04;
        cyc(10);
        check("latch cleared", fault_latched, 0);
        cyc(22 * OC);
        check("ramp masks fault", fault_latched, 0);
        $display("test fault done");
        final_report();
    end
endmodule
